/* hdl/spi_ctrl_regs.svh */
// register addresses, field positions, reset values and timing figures of the serial controller
`ifndef SPI_CTRL_REGS_SVH
`define SPI_CTRL_REGS_SVH

// byte addresses (haddr[15:0]), first controller
`define ADDR_S1_IRQ_ENABLE 16'hA848
`define ADDR_S1_IRQ_PENDING 16'hA808
`define ADDR_S1_TRIGGER_MODE 16'hA854
`define ADDR_S1_FIFO_PORT 16'hC83C
`define ADDR_S1_SHIFT_STATUS 16'hC840
`define ADDR_S1_MODE 16'hC854
`define ADDR_S1_SHIFT_CONFIG 16'hC858
`define ADDR_S1_LINEAR_DIV 16'hC860
`define ADDR_S1_POWER_DIV 16'hC864
// byte addresses, second controller
`define ADDR_S2_IRQ_ENABLE 16'hA84C
`define ADDR_S2_IRQ_PENDING 16'hA80C
`define ADDR_S2_TRIGGER_MODE 16'hA858
`define ADDR_S2_FIFO_PORT 16'hC03C
`define ADDR_S2_SHIFT_STATUS 16'hC040
`define ADDR_S2_MODE 16'hC054
`define ADDR_S2_SHIFT_CONFIG 16'hC058
`define ADDR_S2_LINEAR_DIV 16'hC060
`define ADDR_S2_POWER_DIV 16'hC064

// event bit positions (enable and pending share them)
`define EV_RX_AVAILABLE 0
`define EV_TX_ROOM 1
`define EV_TX_DRAINED 2
`define EV_RX_OVERRUN 3
`define EV_TX_UNDERRUN 4
`define EV_WIDTH 15

// trigger-mode bits
`define TRIG_RX_AVAILABLE 0
`define TRIG_TX_ROOM 1
`define TRIG_TX_DRAINED 2

// shift configuration bits
`define CFG_POLARITY 0
`define CFG_PHASE 1
`define CFG_LSB_FIRST 2
`define CFG_UNDERRUN_REPEAT 3
`define CFG_MASTER 4
`define CFG_RECEIVER_PACED 5

// shift status bits
`define STAT_RX_OVERRUN 0
`define STAT_RX_AVAILABLE 1
`define STAT_TX_ROOM 2
`define STAT_TX_DRAINED 3

// controller function field values
`define FUNC_DISABLED 2'h0
`define FUNC_SPI 2'h2

// reset values and fixed bytes
`define RST_ZERO 32'h00000000
`define BUSY_TOKEN 8'hFF

// serial clock base rate against the bus clock, both in MHz
`define HCLK_FREQ_MHZ 200
`define SCLK_BASE_MHZ 12
// half-period ticks come at twice the base rate
`define SCLK_STEP (2 * `SCLK_BASE_MHZ)
`define SCLK_MOD (`HCLK_FREQ_MHZ)

`endif

/* hdl/spi_ctrl_pkg.sv */
// types shared by the serial controller design
package spi_ctrl_pkg;
	// register selected inside one controller
	typedef enum logic [3:0] {
		SEL_NONE = 4'h0,
		SEL_IRQ_ENABLE = 4'h1,
		SEL_IRQ_PENDING = 4'h2,
		SEL_TRIGGER_MODE = 4'h3,
		SEL_FIFO_PORT = 4'h4,
		SEL_SHIFT_STATUS = 4'h5,
		SEL_MODE = 4'h6,
		SEL_SHIFT_CONFIG = 4'h7,
		SEL_LINEAR_DIV = 4'h8,
		SEL_POWER_DIV = 4'h9
	} reg_sel_t;

	// shifter state
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_SHIFT = 1'b1
	} shift_state_t;

	// pins arriving from the serial link
	typedef struct packed {
		logic sck;
		logic mosi;
		logic miso;
		logic ssel_n;
	} spi_pins_in_t;

	// pins driven toward the serial link, enable high while driving
	typedef struct packed {
		logic sck_o;
		logic sck_oe;
		logic mosi_o;
		logic mosi_oe;
		logic miso_o;
		logic miso_oe;
	} spi_pins_out_t;
endpackage

/* hdl/serial_spi_irq_control.sv */
// two SPI serial controllers with event flags, FIFOs, clock prescaler and AHB-Lite register slave
// Contract
// - an event reaches the interrupt output only while its enable bit is set
// - DMA buffer unload events have enables at bits 11, 12, 9, 10; no DMA here, so those event bits stay zero
// - transmitter-drained event is edge triggered at 0, level triggered at 1
// - transmit-room event is edge triggered at 0, level triggered at 1
// - receive-available event is edge triggered at 0, level triggered at 1
// - writing the data register appends its low byte to the transmit FIFO
// - reading data pops oldest receive byte and clears the overrun flag
// - asynchronous mode parity and framing status follow data reads, first controller only; no asynchronous receiver here, so neither exists
// - master starts on transmit data, or on receive room when receiver-paced
// - configuration bit 4 selects master, clear selects slave
// - slave underrun sends 0xFF, or repeats last byte when bit 3 set
// - underrun policy changes apply only when transmit FIFO and shifter are empty
// - bit 2 clear shifts most significant bit first, set least first
// - phase bit clear samples on leading edge, set on second edge
// - polarity bit clear gives rising leading edge, set falling
// - status bit 3 shows transmit FIFO and shifter both empty
// - status bit 2 shows transmit FIFO has room for a byte
// - status bit 1 shows receive FIFO holds a byte
// - status bit 0 sets on byte arriving into full FIFO, clears on data read
// - master clock is 12 MHz over (LIN+1) times two to EXP
// - exponent field resets to zero and scales clock by power of two
// - receive-available edge mode fires on rise, level mode while high
// - controller acts as SPI only when function field is 2, 0 disables
// - each event latches its pending flag whatever its enable bit
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "spi_ctrl_regs.svh"

module spi_channel
	import spi_ctrl_pkg::*;
#(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic wr_en,
	input wire logic rd_en,
	input reg_sel_t sel,
	input wire logic [31:0] wdata,
	output logic [31:0] rdata,
	input spi_pins_in_t pins_in,
	output spi_pins_out_t pins_out,
	output logic irq
);
	localparam int AW = $clog2(FIFO_DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(FIFO_DEPTH);

	logic [`EV_WIDTH-1:0] enable_reg;
	logic [`EV_WIDTH-1:0] pending_reg;
	logic [2:0] trig_reg;
	logic [1:0] func_reg;
	logic [5:0] cfg_reg;
	logic [3:0] lin_reg;
	logic [3:0] exp_reg;
	logic repeat_eff_reg;
	logic overrun_reg;
	logic [7:0] tx_mem [FIFO_DEPTH];
	logic [7:0] rx_mem [FIFO_DEPTH];
	logic [AW-1:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
	logic [AW:0] tx_cnt_reg, rx_cnt_reg;
	shift_state_t state_reg;
	logic [3:0] edge_cnt_reg;
	logic [7:0] tx_sh_reg, rx_sh_reg, last_byte_reg;
	logic sck_reg;
	logic [7:0] acc_reg;
	logic [19:0] half_cnt_reg;
	logic [2:0] cond_prev_reg;
	logic [2:0] sck_sync_reg, mosi_sync_reg, miso_sync_reg, ssel_sync_reg;

	// decoded state
	logic spi_on, master_on, slave_on, tx_empty, tx_full, rx_empty, rx_full, tx_drained;
	logic data_wr, data_rd, tx_push, tx_pop, rx_push, rx_pop;
	logic load, edge_ev, sample_edge, change_edge, byte_done, in_bit, underrun;
	logic [7:0] load_byte, rx_new;
	logic [8:0] acc_sum;
	logic tick, m_edge, s_edge, ssel_low;
	logic [19:0] half_len;
	logic [2:0] cond_now;
	logic [`EV_WIDTH-1:0] events;

	assign spi_on = (func_reg == `FUNC_SPI);
	assign master_on = spi_on && cfg_reg[`CFG_MASTER];
	assign slave_on = spi_on && !cfg_reg[`CFG_MASTER];
	assign tx_empty = (tx_cnt_reg == '0);
	assign tx_full = (tx_cnt_reg == FULL_CNT);
	assign rx_empty = (rx_cnt_reg == '0);
	assign rx_full = (rx_cnt_reg == FULL_CNT);
	assign tx_drained = tx_empty && (state_reg == ST_IDLE);
	assign data_wr = wr_en && (sel == SEL_FIFO_PORT);
	assign data_rd = rd_en && (sel == SEL_FIFO_PORT);
	assign ssel_low = !ssel_sync_reg[1];

	// reference tick at twice 12 MHz by fractional accumulation
	always_comb begin
		acc_sum = {1'b0, acc_reg} + 9'(`SCLK_STEP);
		tick = (acc_sum >= 9'(`SCLK_MOD));
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_reg <= 8'h00;
		end else if (tick) begin
			acc_reg <= 8'(acc_sum - 9'(`SCLK_MOD));
		end else begin
			acc_reg <= acc_sum[7:0];
		end
	end

	// half period in ticks: (LIN+1) shifted by EXP
	assign half_len = 20'(({16'h0000, lin_reg} + 20'h00001) << exp_reg);
	assign m_edge = master_on && (state_reg == ST_SHIFT) && tick && (half_cnt_reg == half_len - 20'h00001);

	// master half-period counter and clock level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			half_cnt_reg <= 20'h00000;
			sck_reg <= 1'b0;
		end else if (state_reg == ST_IDLE || !master_on) begin
			half_cnt_reg <= 20'h00000;
			sck_reg <= cfg_reg[`CFG_POLARITY];
		end else if (m_edge) begin
			half_cnt_reg <= 20'h00000;
			sck_reg <= !sck_reg;
		end else if (tick) begin
			half_cnt_reg <= half_cnt_reg + 20'h00001;
		end
	end

	// two-flop synchronisers plus a third stage for the clock edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sck_sync_reg <= 3'h0;
			mosi_sync_reg <= 3'h0;
			miso_sync_reg <= 3'h0;
			ssel_sync_reg <= 3'h7;
		end else begin
			sck_sync_reg <= {sck_sync_reg[1:0], pins_in.sck};
			mosi_sync_reg <= {mosi_sync_reg[1:0], pins_in.mosi};
			miso_sync_reg <= {miso_sync_reg[1:0], pins_in.miso};
			ssel_sync_reg <= {ssel_sync_reg[1:0], pins_in.ssel_n};
		end
	end

	// slave follows the outside clock; the edge count tells leading from trailing
	assign s_edge = slave_on && (state_reg == ST_SHIFT) && ssel_low && (sck_sync_reg[1] != sck_sync_reg[2]);
	assign edge_ev = master_on ? m_edge : s_edge;
	assign in_bit = master_on ? miso_sync_reg[1] : mosi_sync_reg[1];
	// even counts are leading edges
	assign sample_edge = edge_ev && (edge_cnt_reg[0] == cfg_reg[`CFG_PHASE]);
	assign change_edge = edge_ev && (edge_cnt_reg[0] != cfg_reg[`CFG_PHASE]) && (edge_cnt_reg != 4'h0);
	assign byte_done = edge_ev && (edge_cnt_reg == 4'hF);
	assign rx_new = cfg_reg[`CFG_LSB_FIRST] ? {in_bit, rx_sh_reg[7:1]} : {rx_sh_reg[6:0], in_bit};

	// start of a byte: master by its pacing choice, slave while selected
	always_comb begin
		load = 1'b0;
		underrun = 1'b0;
		load_byte = tx_mem[tx_rp_reg];
		if (state_reg == ST_IDLE) begin
			if (master_on) begin
				load = cfg_reg[`CFG_RECEIVER_PACED] ? !rx_full : !tx_empty;
			end else if (slave_on) begin
				load = ssel_low;
				underrun = ssel_low && tx_empty;
			end
		end
		if (tx_empty) begin
			load_byte = (slave_on && repeat_eff_reg) ? last_byte_reg : `BUSY_TOKEN;
		end
	end

	assign tx_pop = load && !tx_empty;
	assign tx_push = data_wr && !tx_full;
	assign rx_push = byte_done && sample_edge ? !rx_full : (byte_done && !rx_full);
	assign rx_pop = data_rd && !rx_empty;

	// shifter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_IDLE;
			edge_cnt_reg <= 4'h0;
			tx_sh_reg <= 8'h00;
			rx_sh_reg <= 8'h00;
			last_byte_reg <= `BUSY_TOKEN;
		end else if (!spi_on || (slave_on && !ssel_low)) begin
			state_reg <= ST_IDLE; // deselect drops a partial byte
			edge_cnt_reg <= 4'h0;
		end else if (load) begin
			state_reg <= ST_SHIFT;
			edge_cnt_reg <= 4'h0;
			tx_sh_reg <= load_byte;
			last_byte_reg <= load_byte;
		end else if (edge_ev) begin
			edge_cnt_reg <= edge_cnt_reg + 4'h1;
			if (sample_edge) begin
				rx_sh_reg <= rx_new;
			end
			if (change_edge) begin
				tx_sh_reg <= cfg_reg[`CFG_LSB_FIRST] ? {1'b0, tx_sh_reg[7:1]} : {tx_sh_reg[6:0], 1'b0};
			end
			if (byte_done) begin
				state_reg <= ST_IDLE;
			end
		end
	end

	// transmit FIFO
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_wp_reg <= '0;
			tx_rp_reg <= '0;
			tx_cnt_reg <= '0;
		end else begin
			if (tx_push) begin
				tx_wp_reg <= tx_wp_reg + 1'b1;
			end
			if (tx_pop) begin
				tx_rp_reg <= tx_rp_reg + 1'b1;
			end
			tx_cnt_reg <= tx_cnt_reg + (AW + 1)'(tx_push) - (AW + 1)'(tx_pop);
		end
	end

	always_ff @(posedge hclk) begin
		if (tx_push) begin
			tx_mem[tx_wp_reg] <= wdata[7:0];
		end
		if (byte_done && !rx_full) begin
			rx_mem[rx_wp_reg] <= sample_edge ? rx_new : rx_sh_reg;
		end
	end

	// receive FIFO; a byte into a full FIFO is lost and flagged
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_wp_reg <= '0;
			rx_rp_reg <= '0;
			rx_cnt_reg <= '0;
		end else begin
			if (rx_push) begin
				rx_wp_reg <= rx_wp_reg + 1'b1;
			end
			if (rx_pop) begin
				rx_rp_reg <= rx_rp_reg + 1'b1;
			end
			rx_cnt_reg <= rx_cnt_reg + (AW + 1)'(rx_push) - (AW + 1)'(rx_pop);
		end
	end

	// overrun: a new overrun in the read cycle wins over the clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			overrun_reg <= 1'b0;
		end else if (byte_done && rx_full) begin
			overrun_reg <= 1'b1;
		end else if (data_rd) begin
			overrun_reg <= 1'b0;
		end
	end

	// underrun policy is taken up only when nothing is queued or shifting
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			repeat_eff_reg <= 1'b0;
		end else if (tx_drained) begin
			repeat_eff_reg <= cfg_reg[`CFG_UNDERRUN_REPEAT];
		end
	end

	// software registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable_reg <= '0;
			trig_reg <= 3'h0;
			func_reg <= `FUNC_DISABLED;
			cfg_reg <= 6'h00;
			lin_reg <= 4'h0;
			exp_reg <= 4'h0;
		end else if (wr_en) begin
			case (sel)
				SEL_IRQ_ENABLE: enable_reg <= wdata[`EV_WIDTH-1:0];
				SEL_TRIGGER_MODE: trig_reg <= wdata[2:0];
				SEL_MODE: func_reg <= wdata[1:0];
				SEL_SHIFT_CONFIG: cfg_reg <= wdata[5:0];
				SEL_LINEAR_DIV: lin_reg <= wdata[3:0];
				SEL_POWER_DIV: exp_reg <= wdata[3:0];
				default: begin
				end
			endcase
		end
	end

	// level conditions and their edge or level event form
	assign cond_now = {tx_drained, !tx_full, !rx_empty};
	always_comb begin
		events = '0; // no asynchronous receiver here, so parity and framing faults never rise
		events[`EV_RX_AVAILABLE] = trig_reg[`TRIG_RX_AVAILABLE] ? cond_now[0] : (cond_now[0] && !cond_prev_reg[0]);
		events[`EV_TX_ROOM] = trig_reg[`TRIG_TX_ROOM] ? cond_now[1] : (cond_now[1] && !cond_prev_reg[1]);
		events[`EV_TX_DRAINED] = trig_reg[`TRIG_TX_DRAINED] ? cond_now[2] : (cond_now[2] && !cond_prev_reg[2]);
		events[`EV_RX_OVERRUN] = byte_done && rx_full;
		events[`EV_TX_UNDERRUN] = underrun;
	end

	// pending flags latch regardless of enable; set wins over write-one clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pending_reg <= '0;
			cond_prev_reg <= 3'h0;
			irq <= 1'b0;
		end else begin
			cond_prev_reg <= cond_now;
			pending_reg <= (pending_reg & ~((wr_en && sel == SEL_IRQ_PENDING) ? wdata[`EV_WIDTH-1:0] : '0))
				| events;
			irq <= |(pending_reg & enable_reg);
		end
	end

	// pins, registered; outputs idle undriven when not in SPI function
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pins_out <= '0;
		end else begin
			pins_out.sck_o <= sck_reg;
			pins_out.sck_oe <= master_on;
			pins_out.mosi_o <= cfg_reg[`CFG_LSB_FIRST] ? tx_sh_reg[0] : tx_sh_reg[7];
			pins_out.mosi_oe <= master_on;
			pins_out.miso_o <= cfg_reg[`CFG_LSB_FIRST] ? tx_sh_reg[0] : tx_sh_reg[7];
			pins_out.miso_oe <= slave_on && ssel_low;
		end
	end

	// read view of the selected register
	always_comb begin
		rdata = `RST_ZERO;
		case (sel)
			SEL_IRQ_ENABLE: rdata[`EV_WIDTH-1:0] = enable_reg;
			SEL_IRQ_PENDING: rdata[`EV_WIDTH-1:0] = pending_reg;
			SEL_TRIGGER_MODE: rdata[2:0] = trig_reg;
			SEL_FIFO_PORT: rdata[7:0] = rx_empty ? 8'h00 : rx_mem[rx_rp_reg];
			SEL_SHIFT_STATUS: begin
				rdata[`STAT_TX_DRAINED] = tx_drained;
				rdata[`STAT_TX_ROOM] = !tx_full;
				rdata[`STAT_RX_AVAILABLE] = !rx_empty;
				rdata[`STAT_RX_OVERRUN] = overrun_reg;
			end
			SEL_MODE: rdata[1:0] = func_reg;
			SEL_SHIFT_CONFIG: rdata[5:0] = cfg_reg;
			SEL_LINEAR_DIV: rdata[3:0] = lin_reg;
			SEL_POWER_DIV: rdata[3:0] = exp_reg;
			default: rdata = `RST_ZERO;
		endcase
	end
endmodule

module serial_spi_irq_control
	import spi_ctrl_pkg::*;
#(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input spi_pins_in_t [1:0] pins_in,
	output spi_pins_out_t [1:0] pins_out,
	output logic [1:0] irq
);
	logic pend_reg;
	logic write_reg;
	logic [15:0] addr_reg;
	logic hit_ch;
	reg_sel_t hit_sel;
	logic [31:0] ch_rdata [2];

	// address to controller and register
	always_comb begin
		hit_ch = 1'b0;
		hit_sel = SEL_NONE;
		case (addr_reg)
			`ADDR_S1_IRQ_ENABLE: hit_sel = SEL_IRQ_ENABLE;
			`ADDR_S1_IRQ_PENDING: hit_sel = SEL_IRQ_PENDING;
			`ADDR_S1_TRIGGER_MODE: hit_sel = SEL_TRIGGER_MODE;
			`ADDR_S1_FIFO_PORT: hit_sel = SEL_FIFO_PORT;
			`ADDR_S1_SHIFT_STATUS: hit_sel = SEL_SHIFT_STATUS;
			`ADDR_S1_MODE: hit_sel = SEL_MODE;
			`ADDR_S1_SHIFT_CONFIG: hit_sel = SEL_SHIFT_CONFIG;
			`ADDR_S1_LINEAR_DIV: hit_sel = SEL_LINEAR_DIV;
			`ADDR_S1_POWER_DIV: hit_sel = SEL_POWER_DIV;
			`ADDR_S2_IRQ_ENABLE: begin hit_ch = 1'b1; hit_sel = SEL_IRQ_ENABLE; end
			`ADDR_S2_IRQ_PENDING: begin hit_ch = 1'b1; hit_sel = SEL_IRQ_PENDING; end
			`ADDR_S2_TRIGGER_MODE: begin hit_ch = 1'b1; hit_sel = SEL_TRIGGER_MODE; end
			`ADDR_S2_FIFO_PORT: begin hit_ch = 1'b1; hit_sel = SEL_FIFO_PORT; end
			`ADDR_S2_SHIFT_STATUS: begin hit_ch = 1'b1; hit_sel = SEL_SHIFT_STATUS; end
			`ADDR_S2_MODE: begin hit_ch = 1'b1; hit_sel = SEL_MODE; end
			`ADDR_S2_SHIFT_CONFIG: begin hit_ch = 1'b1; hit_sel = SEL_SHIFT_CONFIG; end
			`ADDR_S2_LINEAR_DIV: begin hit_ch = 1'b1; hit_sel = SEL_LINEAR_DIV; end
			`ADDR_S2_POWER_DIV: begin hit_ch = 1'b1; hit_sel = SEL_POWER_DIV; end
			default: hit_sel = SEL_NONE;
		endcase
	end

	// one wait state per transfer so read data leaves a flip-flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_reg <= 1'b0;
			write_reg <= 1'b0;
			addr_reg <= 16'h0000;
			hreadyout <= 1'b1;
			hrdata <= `RST_ZERO;
			hresp <= 1'b0;
		end else if (pend_reg) begin
			pend_reg <= 1'b0;
			hreadyout <= 1'b1;
			hrdata <= write_reg ? `RST_ZERO : ch_rdata[hit_ch];
		end else if (hsel && htrans[1] && hready) begin
			pend_reg <= 1'b1;
			write_reg <= hwrite;
			addr_reg <= haddr[15:0];
			hreadyout <= 1'b0;
		end
	end

	// both controllers share one slave port
	for (genvar c = 0; c < 2; c++) begin : g_ch
		spi_channel #(
			.FIFO_DEPTH(FIFO_DEPTH)
		) u_channel (
			.hclk(hclk),
			.hresetn(hresetn),
			.wr_en(pend_reg && write_reg && (hit_ch == 1'(c))),
			.rd_en(pend_reg && !write_reg && (hit_ch == 1'(c))),
			.sel(hit_sel),
			.wdata(hwdata),
			.rdata(ch_rdata[c]),
			.pins_in(pins_in[c]),
			.pins_out(pins_out[c]),
			.irq(irq[c])
		);
	end
endmodule

/* testbench/serial_spi_irq_control_asserts.sv */
// concurrent checks on the serial controller ports
`timescale 1ns/100ps
`include "spi_ctrl_regs.svh"
module serial_spi_irq_control_checker
	import spi_ctrl_pkg::*;
#(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input spi_pins_in_t [1:0] pins_in,
	input spi_pins_out_t [1:0] pins_out,
	input wire logic [1:0] irq
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// a transfer is taken when selected, active and ready
	sequence taken;
		hsel && htrans[1] && hready;
	endsequence
	// a write whose data phase has just been sampled
	sequence wr_of(a);
		taken ##0 (hwrite && haddr[15:0] == a) ##1 1'b1;
	endsequence
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");
	a_wait_one: assert property (taken |=> !hreadyout ##1 hreadyout)
		else $error("wait state count wrong");
	a_write_rdata: assert property (taken ##0 hwrite |-> ##2 hrdata == 32'h0)
		else $error("read data after write not zero");
	a_unmapped_zero: assert property (taken ##0 (!hwrite && haddr[15:0] == 16'hC000) |-> ##2 hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_irq_masked: assert property (
		wr_of(`ADDR_S1_IRQ_ENABLE) ##0 hwdata[14:0] == 15'h0 |-> ##2 !irq[0] [*2])
		else $error("interrupt with all enables off");
	a_master_miso_off: assert property (
		wr_of(`ADDR_S1_SHIFT_CONFIG) ##0 hwdata[4] |-> ##3 !pins_out[0].miso_oe [*2])
		else $error("master drives its data input");
	a_slave_sck_off: assert property (
		wr_of(`ADDR_S2_SHIFT_CONFIG) ##0 !hwdata[4] |-> ##3 !pins_out[1].sck_oe [*2])
		else $error("slave drives serial clock");
	a_sck_half_min: assert property (
		pins_out[0].sck_oe && $changed(pins_out[0].sck_o) |=> $stable(pins_out[0].sck_o) [*7])
		else $error("serial clock half period too short");
endmodule

bind serial_spi_irq_control serial_spi_irq_control_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.hclk, .hresetn, .hsel,
	.haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pins_in, .pins_out, .irq);

/* testbench/spi_peer_model.sv */
// behavioural spi slave peer that answers a fixed byte
`timescale 1ns/100ps
module spi_peer_model (
	input wire logic sck,
	input wire logic mosi,
	output logic miso,
	input wire logic arm,
	input wire logic [2:0] mode_bits,
	input wire logic [7:0] reply,
	output logic [7:0] got
);
	int idx;
	int n;
	logic [7:0] rx;
	// bit i of the reply in the configured order
	function automatic logic pick(input int i);
		return mode_bits[2] ? reply[i] : reply[7 - i];
	endfunction
	// select is held low, so the peer is always addressed
	initial begin
		miso = 1'b1;
		got = 8'h00;
		rx = 8'h00;
		idx = 0;
		n = 0;
	end
	// rearm after a mode change; phase 0 shows the first bit early
	always @(posedge arm) begin
		n = 0;
		idx = mode_bits[1] ? 0 : 1;
		if (!mode_bits[1]) miso = pick(0);
	end
	// leading edge leaves the idle level; phase picks the sample edge
	always @(sck) begin
		if ((sck !== mode_bits[0]) ^ mode_bits[1]) begin
			rx = mode_bits[2] ? {mosi, rx[7:1]} : {rx[6:0], mosi};
			n++;
			if (n == 8) begin
				got = rx;
				n = 0;
				if (mode_bits[1]) idx = 0;
			end
		end else if (idx == 8) begin
			miso = pick(0);
			idx = 1;
		end else begin
			miso = pick(idx);
			idx++;
		end
	end
endmodule

/* testbench/tb.sv */
// self-checking bench for the serial controller
`timescale 1ns/100ps
`include "spi_ctrl_regs.svh"
`define CHK(nm, g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb
	import spi_ctrl_pkg::*;
();
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, arm, ssel1_n, peer_miso;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans, irq;
	logic [2:0] hsize;
	logic [7:0] reply, got, cfg;
	spi_pins_in_t [1:0] pins_in;
	spi_pins_out_t [1:0] pins_out;
	int miscompares, comparisons;
	// second controller is wired as slave to the first; peer answers when it is not selected
	assign pins_in[0] = {1'b0, 1'b0, ssel1_n ? peer_miso : pins_out[1].miso_o, 1'b1};
	assign pins_in[1] = {pins_out[0].sck_o, pins_out[0].mosi_o, 1'b0, ssel1_n};
	serial_spi_irq_control #(.FIFO_DEPTH(4)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pins_in, .pins_out, .irq);
	spi_peer_model peer (.sck(pins_out[0].sck_o), .mosi(pins_out[0].mosi_o), .miso(peer_miso), .arm,
		.mode_bits(cfg[2:0]), .reply, .got);
	// 200 MHz bus clock
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	task automatic end_of_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// one single transfer; the master never assumes a latency
	task automatic bus(input logic [15:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		haddr <= {16'h0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsel <= 1'b1;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		bus(a, 1'b1, d, r);
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0, r);
		`CHK($sformatf("reg_%h", a), r, e)
	endtask
	task automatic wait_bit(input logic [15:0] a, input int b);
		logic [31:0] q;
		q = 32'h0;
		while (q[b] !== 1'b1) bus(a, 1'b0, 32'h0, q);
	endtask
	// hang guard, well beyond the few thousand cycles needed
	initial begin
		repeat (60000) @(posedge hclk);
		miscompares++;
		end_of_test();
	end
	// main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		arm = 1'b0;
		ssel1_n = 1'b1;
		cfg = 8'h00;
		reply = 8'h00;
		miscompares = 0;
		comparisons = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		`CHK("irq", irq, 2'h0)
		rd(`ADDR_S1_IRQ_ENABLE, 32'h0);
		rd(`ADDR_S2_SHIFT_CONFIG, 32'h0);
		rd(`ADDR_S2_POWER_DIV, 32'h0);
		rd(`ADDR_S1_SHIFT_STATUS, 32'hC);
		rd(16'hC000, 32'h0);
		wr(`ADDR_S2_IRQ_ENABLE, 32'hFFFFFFFF);
		rd(`ADDR_S2_IRQ_ENABLE, 32'h7FFF);
		wr(`ADDR_S2_IRQ_ENABLE, 32'h0);
		$display("test reset done");
		// edge mode does not refire on a held condition, level mode does
		for (int i = 1; i < 3; i++) begin
			wr(`ADDR_S1_IRQ_ENABLE, 32'h1 << i);
			wr(`ADDR_S1_IRQ_PENDING, 32'h7FFF);
			repeat (3) @(posedge hclk);
			`CHK("irq_edge", irq[0], 1'b0)
			wr(`ADDR_S1_TRIGGER_MODE, 32'h1 << i);
			repeat (3) @(posedge hclk);
			`CHK("irq_level", irq[0], 1'b1)
			wr(`ADDR_S1_IRQ_ENABLE, 32'h0);
			repeat (3) @(posedge hclk);
			`CHK("irq_masked", irq[0], 1'b0)
			wr(`ADDR_S1_TRIGGER_MODE, 32'h0);
			rd(`ADDR_S1_IRQ_PENDING, 32'h1 << i);
		end
		$display("test events done");
		// master transfers in every phase and polarity most significant bit first, and least first with phase and polarity clear
		wr(`ADDR_S1_MODE, 32'h2);
		wr(`ADDR_S1_IRQ_ENABLE, 32'h1);
		for (int k = 0; k < 5; k++) begin
			cfg = (k == 4) ? 8'h10 : 8'h11 + 8'(k);
			reply = 8'h1C + 8'(k);
			wr(`ADDR_S1_SHIFT_CONFIG, {24'h0, cfg});
			// a polarity change moves the idle clock pin; let it settle before the peer rearms
			repeat (8) @(posedge hclk);
			arm <= 1'b1;
			@(posedge hclk);
			arm <= 1'b0;
			wr(`ADDR_S1_FIFO_PORT, 32'hA1 + k);
			wait_bit(`ADDR_S1_SHIFT_STATUS, 1);
			repeat (2) @(posedge hclk);
			`CHK("irq_rx", irq[0], 1'b1)
			rd(`ADDR_S1_FIFO_PORT, {24'h0, reply});
			`CHK("peer_got", got, 8'hA1 + 8'(k))
			wr(`ADDR_S1_IRQ_PENDING, 32'h7FFF);
			repeat (3) @(posedge hclk);
			`CHK("irq_clr", irq[0], 1'b0)
		end
		$display("test master done");
		// one byte more than the receive FIFO holds
		for (int j = 0; j < 5; j++) begin
			wr(`ADDR_S1_FIFO_PORT, 32'h0);
			wait_bit(`ADDR_S1_SHIFT_STATUS, 3);
		end
		repeat (4) @(posedge hclk);
		rd(`ADDR_S1_SHIFT_STATUS, 32'hF);
		rd(`ADDR_S1_FIFO_PORT, {24'h0, reply});
		rd(`ADDR_S1_SHIFT_STATUS, 32'hE);
		repeat (3) rd(`ADDR_S1_FIFO_PORT, {24'h0, reply});
		rd(`ADDR_S1_SHIFT_STATUS, 32'hC);
		$display("test overrun done");
		// slave underrun sends the busy token, then repeats the last byte
		wr(`ADDR_S2_MODE, 32'h2);
		wr(`ADDR_S1_LINEAR_DIV, 32'h1);
		for (int k = 0; k < 3; k++) begin
			wr(`ADDR_S2_SHIFT_CONFIG, (k > 0) ? 32'h8 : 32'h0);
			if (k == 1) wr(`ADDR_S2_FIFO_PORT, 32'h81);
			ssel1_n <= 1'b0;
			repeat (12) @(posedge hclk);
			wr(`ADDR_S1_FIFO_PORT, 32'h5A + k);
			wait_bit(`ADDR_S1_SHIFT_STATUS, 1);
			wait_bit(`ADDR_S2_SHIFT_STATUS, 1);
			rd(`ADDR_S1_FIFO_PORT, (k > 0) ? 32'h81 : 32'hFF);
			rd(`ADDR_S2_FIFO_PORT, 32'h5A + k);
			ssel1_n <= 1'b1;
			repeat (4) @(posedge hclk);
		end
		bus(`ADDR_S2_IRQ_PENDING, 1'b0, 32'h0, r);
		`CHK("underrun", r[4], 1'b1)
		wr(`ADDR_S2_IRQ_ENABLE, 32'h10);
		repeat (2) @(posedge hclk);
		`CHK("irq_slave", irq[1], 1'b1)
		$display("test slave done");
		// receiver-paced master clocks busy tokens until the receive FIFO is full, then waits
		wr(`ADDR_S1_SHIFT_CONFIG, 32'h30);
		repeat (1500) @(posedge hclk);
		rd(`ADDR_S1_SHIFT_STATUS, 32'hE);
		rd(`ADDR_S1_FIFO_PORT, {24'h0, reply});
		`CHK("paced_got", got, 8'hFF)
		$display("test paced done");
		end_of_test();
	end
endmodule
